// ---- hdl/port1_pkg.sv ----
// Purpose: Constants and carrier types for the eight-bit port with PWM pin sharing.
// Assumes: APB slave with 32-bit data; every register takes one aligned word.
// Notes on behaviour
// [R1] Eight two-way pins, each shareable with PWM.
// [R2] Direction bit: 1 output, 0 input, per pin.
// [R3] Output latch readable, writable, resets to zero. A read of the latch word returns the latch on output bits only.
// [R4] Port read returns latch on output bits.
// [R5] Port read returns pin level on input bits.
// [R6] Pin driver selects latch or PWM channel.
// [R7] Input; latch when enable 0; PWM when 1.
// [R8] Pull-up on when input and control bit 1.
// [R9] Pull-ups off in reset and hardware standby.
// [R10] Direction register reads zero, no side effect.
package port1_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int PORT_W = 8;
    localparam logic [ADDR_W-1:0] OFS_DIRECTION = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_OUTPUT_LATCH = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_PULLUP_CONTROL = 12'h008;

    // ------------------------------------------------------------------
    // Reset values and fixed read values
    // ------------------------------------------------------------------
    localparam logic [PORT_W-1:0] RST_DIRECTION = 8'h00;
    localparam logic [PORT_W-1:0] RST_OUTPUT_LATCH = 8'h00;
    localparam logic [PORT_W-1:0] RST_PULLUP_CONTROL = 8'h00;
    localparam logic [PORT_W-1:0] DIRECTION_READ = 8'h00;
    localparam logic [DATA_W-PORT_W-1:0] UPPER_ZERO = 24'h000000;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic sel_dir;
        logic sel_latch;
        logic sel_pull;
        logic hit;
    } reg_sel_t;

    typedef struct packed {
        logic [PORT_W-1:0] dir;
        logic [PORT_W-1:0] latch;
        logic [PORT_W-1:0] pullctl;
        logic [PORT_W-1:0] rdata;
        logic err;
    } port_state_t;

    typedef struct packed {
        logic [PORT_W-1:0] pin_out;
        logic [PORT_W-1:0] pin_oe;
        logic [PORT_W-1:0] pull_on;
        logic [PORT_W-1:0] rd_view;
    } pin_bus_t;

endpackage

// ---- hdl/port1_reg_decode.sv ----
// Purpose: Address decoder for the port register words.
// Assumes: Address bits below the word boundary are ignored.
// Notes: Pure combinational; the caller registers whatever it needs.
module port1_reg_decode
    import port1_pkg::*;
(
    input wire logic [port1_pkg::ADDR_W-1:0] paddr, // Bus address
    output port1_pkg::reg_sel_t sel // One-hot register select
);
    import port1_pkg::*;

    // ------------------------------------------------------------------
    // Word match, ignoring byte offset
    // ------------------------------------------------------------------
    function automatic logic word_is(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
        word_is = (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
    endfunction

    // If/else-if decode keeps one select active at most
    always_comb
    begin
        sel = '0;
        if (word_is(paddr, OFS_DIRECTION))
        begin
            sel.sel_dir = 1'b1;
        end
        else if (word_is(paddr, OFS_OUTPUT_LATCH))
        begin
            sel.sel_latch = 1'b1;
        end
        else if (word_is(paddr, OFS_PULLUP_CONTROL))
        begin
            sel.sel_pull = 1'b1;
        end
        sel.hit = sel.sel_dir | sel.sel_latch | sel.sel_pull;
    end

endmodule // port1_reg_decode

// ---- hdl/port1_pin_cell.sv ----
// Purpose: One pin of the port: driver select, pull-up gate, read view.
// Assumes: PWM enable and level come straight from the PWM unit.
// Notes: Combinational; the state lives in the top module.
module port1_pin_cell (
    input wire logic dir, // 1 output, 0 input
    input wire logic latch, // Stored output value
    input wire logic pullctl, // Pull-up control bit
    input wire logic pull_allow, // Low in reset and hardware standby
    input wire logic pwm_oe, // PWM channel output enable
    input wire logic pwm_lvl, // PWM channel level
    input wire logic pin_in, // Level seen on the pin
    output logic pin_out, // Level driven on the pin
    output logic pin_oe, // High while driving the pin
    output logic pull_on, // Pull-up device on
    output logic rd_view // Bit returned on a port read
);

    // Driver select: input, latch, or PWM channel
    always_comb
    begin
        pin_oe = dir; // R2 R7
        pin_out = pwm_oe ? pwm_lvl : latch; // R6 R7
        // Pull-up only on an input with control set, never in reset or standby
        pull_on = ~dir & pullctl & pull_allow; // R8 R9
        // Output bits read back the latch so a loaded pin cannot corrupt them
        rd_view = dir ? latch : pin_in; // R4 R5
    end

endmodule // port1_pin_cell

// ---- hdl/port1_gpio.sv ----
// Purpose: Eight-bit general-purpose port with PWM pin sharing, APB slave.
// Assumes: Pin inputs synchronous to MCLK; zero-wait APB access phase.
// Notes: Read data is captured in the setup cycle and held through access.
//
// Decided for this implementation: the placing of the registers and the APB register port.
module port1_gpio
    import port1_pkg::*;
(
    input wire logic MCLK, // System clock, 250 MHz
    input wire logic RST_N, // Asynchronous reset, active low
    input wire logic HW_STANDBY, // Hardware standby, active high
    input wire logic PSEL, // APB select
    input wire logic PENABLE, // APB access phase
    input wire logic PWRITE, // APB write when high
    input wire logic [port1_pkg::ADDR_W-1:0] PADDR, // APB byte address
    input wire logic [port1_pkg::DATA_W-1:0] PWDATA, // APB write data
    output logic [port1_pkg::DATA_W-1:0] PRDATA, // APB read data
    output logic PREADY, // APB ready
    output logic PSLVERR, // APB error on unmapped word
    input wire logic [port1_pkg::PORT_W-1:0] PWM_OE, // PWM channel output enables
    input wire logic [port1_pkg::PORT_W-1:0] PWM_OUT, // PWM channel levels
    input wire logic [port1_pkg::PORT_W-1:0] PIN_IN, // Pin levels
    output logic [port1_pkg::PORT_W-1:0] PIN_OUT, // Pin drive levels
    output logic [port1_pkg::PORT_W-1:0] PIN_OE, // Pin output enables
    output logic [port1_pkg::PORT_W-1:0] PULLUP_EN // Pull-up enables
);
    import port1_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    port_state_t st_ff;
    port_state_t nxt_st;
    reg_sel_t sel;
    pin_bus_t pins;
    logic setup_ph;
    logic wr_take;
    logic pull_allow;

    // ------------------------------------------------------------------
    // Bus phases
    // ------------------------------------------------------------------
    // Setup captures read data; access commits writes with PREADY high
    assign setup_ph = PSEL & ~PENABLE;
    assign wr_take = PSEL & PENABLE & PWRITE & PREADY;
    assign PREADY = 1'b1;

    port1_reg_decode u_decode (
        .paddr(PADDR),
        .sel(sel)
    );

    // ------------------------------------------------------------------
    // Pin cells
    // ------------------------------------------------------------------
    // Reset is gated in directly so the pull-ups drop without waiting for MCLK
    assign pull_allow = RST_N & ~HW_STANDBY; // R9

    genvar gi;
    generate
        for (gi = 0; gi < PORT_W; gi++)
        begin : g_pin
            port1_pin_cell u_cell (
                .dir(st_ff.dir[gi]),
                .latch(st_ff.latch[gi]),
                .pullctl(st_ff.pullctl[gi]),
                .pull_allow(pull_allow),
                .pwm_oe(PWM_OE[gi]),
                .pwm_lvl(PWM_OUT[gi]),
                .pin_in(PIN_IN[gi]),
                .pin_out(pins.pin_out[gi]),
                .pin_oe(pins.pin_oe[gi]),
                .pull_on(pins.pull_on[gi]),
                .rd_view(pins.rd_view[gi])
            ); // R1
        end
    endgenerate

    assign PIN_OUT = pins.pin_out; // R6
    assign PIN_OE = pins.pin_oe; // R7
    assign PULLUP_EN = pins.pull_on; // R8

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // Register writes at the access edge, read data sampled at setup
    always_comb
    begin
        nxt_st = st_ff;
        if (wr_take)
        begin
            if (sel.sel_dir)
            begin
                nxt_st.dir = PWDATA[PORT_W-1:0]; // R2
            end
            else if (sel.sel_latch)
            begin
                nxt_st.latch = PWDATA[PORT_W-1:0]; // R3
            end
            else if (sel.sel_pull)
            begin
                nxt_st.pullctl = PWDATA[PORT_W-1:0]; // R8
            end
        end
        if (setup_ph)
        begin
            nxt_st.err = ~sel.hit;
            nxt_st.rdata = '0;
            if (!PWRITE)
            begin
                if (sel.sel_dir)
                begin
                    // Write-only word: a read is harmless and returns zero
                    nxt_st.rdata = DIRECTION_READ; // R10
                end
                else if (sel.sel_latch)
                begin
                    nxt_st.rdata = pins.rd_view; // R4 R5
                end
                else if (sel.sel_pull)
                begin
                    nxt_st.rdata = st_ff.pullctl;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            st_ff.dir <= RST_DIRECTION;
            st_ff.latch <= RST_OUTPUT_LATCH; // R3
            st_ff.pullctl <= RST_PULLUP_CONTROL;
            st_ff.rdata <= '0;
            st_ff.err <= 1'b0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // Upper bits read as zero since the port is eight bits wide
    assign PRDATA = {UPPER_ZERO, st_ff.rdata}; // R1
    assign PSLVERR = PSEL & PENABLE & st_ff.err;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RST_N);

    logic acc_rd;
    assign acc_rd = PSEL & PENABLE & ~PWRITE;

    a_upper_zero: assert property (PRDATA[DATA_W-1:PORT_W] == '0) // R1
        else $error("upper read data bits not zero");

    a_dir_write_lands: assert property (
        wr_take && sel.sel_dir |=> st_ff.dir == $past(PWDATA[PORT_W-1:0])) // R2
        else $error("direction write not stored");

    a_latch_write_lands: assert property (
        wr_take && sel.sel_latch |=> st_ff.latch == $past(PWDATA[PORT_W-1:0])) // R3
        else $error("latch write not stored");

    a_read_out_bits: assert property (
        setup_ph && !PWRITE && sel.sel_latch ##1 acc_rd
        |-> (PRDATA[PORT_W-1:0] & st_ff.dir) == (st_ff.latch & st_ff.dir)) // R4
        else $error("output bit read not from latch");

    a_read_in_bits: assert property (
        setup_ph && !PWRITE && sel.sel_latch ##1 acc_rd
        |-> (PRDATA[PORT_W-1:0] & ~st_ff.dir) == ($past(PIN_IN) & ~st_ff.dir)) // R5
        else $error("input bit read not from pin");

    a_pwm_drive: assert property (
        ((PIN_OUT ^ PWM_OUT) & PWM_OE & st_ff.dir) == '0) // R6
        else $error("pwm level not on enabled output pin");

    a_pin_function: assert property (
        PIN_OE == st_ff.dir && ((PIN_OUT ^ st_ff.latch) & ~PWM_OE) == '0) // R7
        else $error("pin function select wrong");

    // Outside standby each pull-up is on exactly for an input bit with control set
    a_pull_gate: assert property (
        !HW_STANDBY |-> PULLUP_EN == (~st_ff.dir & st_ff.pullctl)) // R8
        else $error("pull-up state does not follow direction and control");

    a_pull_standby: assert property (
        HW_STANDBY |-> PULLUP_EN == '0) // R9
        else $error("pull-up on in hardware standby");

    // Reset must be watched while it is asserted, so the default disable is lifted
    a_pull_reset: assert property (
        @(posedge MCLK) disable iff (1'b0) !RST_N |-> PULLUP_EN == '0) // R9
        else $error("pull-up on during reset");

    a_reset_pins: assert property (
        @(posedge MCLK) disable iff (1'b0) !RST_N |-> PIN_OE == '0 && PRDATA == '0) // R2
        else $error("pins driven or read data set during reset");

    a_mapped_no_err: assert property (
        setup_ph && sel.hit |=> !PSLVERR)
        else $error("error flagged on a mapped word");

    a_dir_reads_zero: assert property (
        setup_ph && !PWRITE && sel.sel_dir |=> PRDATA == '0 && $stable(st_ff.dir)) // R10
        else $error("direction read not zero");

    a_unmapped_err: assert property (
        setup_ph && !sel.hit |=> PSLVERR)
        else $error("unmapped access without error");

    c_dir_write: cover property (wr_take && sel.sel_dir && PWDATA[PORT_W-1:0] != '0);
    c_mixed_read: cover property (acc_rd && st_ff.dir != '0 && st_ff.dir != 8'hFF);
    c_pwm_pin: cover property ((PWM_OE & st_ff.dir) != '0);
    c_standby_pull: cover property (HW_STANDBY && (st_ff.pullctl & ~st_ff.dir) != '0);

endmodule // port1_gpio

// ---- testbench/port1_pin_world.sv ----
// Purpose: Far-side model: external pin drivers, pin wire resolution, PWM channels.
// Assumes: Pin level is resolved from the enables of every party on the wire.
// Notes: An undriven pin without pull-up toggles each cycle, so a stale level never passes.
module port1_pin_world
    import port1_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic [port1_pkg::PORT_W-1:0] ext_en, // External driver on
    input wire logic [port1_pkg::PORT_W-1:0] ext_val, // External driver level
    input wire logic [port1_pkg::PORT_W-1:0] pin_oe, // Block drives pin
    input wire logic [port1_pkg::PORT_W-1:0] pin_out, // Block drive level
    input wire logic [port1_pkg::PORT_W-1:0] pull_on, // Pull-up device on
    output logic [port1_pkg::PORT_W-1:0] pwm_lvl, // PWM channel levels
    output logic [port1_pkg::PORT_W-1:0] pin_lvl // Resolved pin level
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [PORT_W-1:0] flt_ff = 8'h55;
    logic [PORT_W-1:0] pwm_ff = 8'h00;
    // --------------------------------------------------------------
    // Waveforms that keep moving, so a late sample shows up
    // --------------------------------------------------------------
    always @(posedge clk)
    begin
        flt_ff <= ~flt_ff;
        pwm_ff <= pwm_ff + 8'h37;
    end
    // Block drive wins, then external driver, then pull-up, else floating
    assign pwm_lvl = pwm_ff;
    assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
        | (~pin_oe & ~ext_en & pull_on) | (~pin_oe & ~ext_en & ~pull_on & flt_ff);
endmodule // port1_pin_world

// ---- testbench/port1_gpio_with_pwm_mux_tb_top.sv ----
// Purpose: Self-checking bench for the eight-bit port with PWM pin sharing.
// Assumes: Zero-wait APB slave; pins sampled at the setup edge of a read.
// Notes: Table rows first, then refused accesses, standby and reset by hand.
module port1_gpio_with_pwm_mux_tb_top;
    import port1_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {logic [7:0] dir, lat, pul, oe, een, ev, rd;} row_t;
    // Direction, latch, pull-up, PWM enable, external enable, external level, read view
    row_t rows [5] = '{'{8'hFF, 8'hA5, 8'h00, 8'h00, 8'h00, 8'h00, 8'hA5},
        '{8'h00, 8'h5A, 8'h00, 8'hFF, 8'hFF, 8'h3C, 8'h3C},
        '{8'hF0, 8'h96, 8'h0F, 8'h3C, 8'h00, 8'h00, 8'h9F},
        '{8'h0F, 8'hC3, 8'hFF, 8'hF0, 8'hF0, 8'h50, 8'h53},
        '{8'h81, 8'h7E, 8'h00, 8'h01, 8'h7E, 8'h24, 8'h24}};
    logic mclk, rst_n, hw_sb, psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [7:0] pwm_oe, pwm_lvl, pin_in, pin_out, pin_oe, pu_en, ext_en, ext_val;
    int err_total = 0;
    int checks_done = 0;
    int cyc = 0;
    port1_gpio DUT (.MCLK(mclk), .RST_N(rst_n), .HW_STANDBY(hw_sb), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .PWM_OE(pwm_oe),
        .PWM_OUT(pwm_lvl), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
        .PULLUP_EN(pu_en));
    port1_pin_world world (.clk(mclk), .ext_en(ext_en), .ext_val(ext_val), .pin_oe(pin_oe),
        .pin_out(pin_out), .pull_on(pu_en), .pwm_lvl(pwm_lvl), .pin_lvl(pin_in));
    // --------------------------------------------------------------
    // Clock, timeout and shared tasks
    // --------------------------------------------------------------
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    // Generous ceiling: the whole sequence needs under 150 cycles
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            err_total++;
            summarize();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Request held until pready is seen high; data taken at that edge only
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic settle();
        @(posedge mclk);
        #1;
    endtask
    task automatic summarize();
        if (err_total == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial
    begin
        {rst_n, hw_sb, psel, penable, pwrite} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        pwm_oe = 8'h00;
        ext_en = 8'h00;
        ext_val = 8'h00;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        settle();
        chk(pin_oe, 8'h00);
        chk(pu_en, 8'h00);
        // One row per pin mix; writes go one after another through the bus, an idle cycle apart
        foreach (rows[i])
        begin
            @(posedge mclk);
            pwm_oe <= rows[i].oe;
            ext_en <= rows[i].een;
            ext_val <= rows[i].ev;
            apb(1'b1, OFS_DIRECTION, {24'h0, rows[i].dir});
            apb(1'b1, OFS_OUTPUT_LATCH, {24'h0, rows[i].lat});
            apb(1'b1, OFS_PULLUP_CONTROL, {24'h0, rows[i].pul});
            settle();
            chk(pin_oe, rows[i].dir);
            chk(pin_out, (pwm_oe & pwm_lvl) | (~pwm_oe & rows[i].lat));
            chk(pu_en, ~rows[i].dir & rows[i].pul);
            apb(1'b0, OFS_OUTPUT_LATCH, 32'h0);
            chk(r, {24'h0, rows[i].rd});
            chk(e, 1'b0);
        end
        // Direction word reads zero and leaves the pins as they were
        apb(1'b0, OFS_DIRECTION, 32'h0);
        chk(r, 32'h0);
        settle();
        chk(pin_oe, 8'h81);
        // Unmapped word is refused and changes nothing
        apb(1'b1, 12'h00C, 32'hFF);
        chk(e, 1'b1);
        apb(1'b0, 12'h00C, 32'h0);
        chk(e, 1'b1);
        chk(r, 32'h0);
        settle();
        chk(pin_oe, 8'h81);
        // Pull-ups follow registers, then standby forces them off
        apb(1'b1, OFS_DIRECTION, 32'h0);
        apb(1'b1, OFS_PULLUP_CONTROL, 32'h5A);
        apb(1'b0, OFS_PULLUP_CONTROL, 32'h0);
        chk(r, 32'h5A);
        settle();
        chk(pu_en, 8'h5A);
        // Standby and reset change on a rising edge like every other input
        @(posedge mclk);
        hw_sb <= 1'b1;
        settle();
        chk(pu_en, 8'h00);
        @(posedge mclk);
        hw_sb <= 1'b0;
        settle();
        chk(pu_en, 8'h5A);
        // Reset in mid-run clears every register
        apb(1'b1, OFS_DIRECTION, 32'h0F);
        apb(1'b1, OFS_OUTPUT_LATCH, 32'h3C);
        settle();
        chk(pu_en, 8'h50);
        @(posedge mclk);
        rst_n <= 1'b0;
        settle();
        chk(pu_en, 8'h00);
        chk(pin_oe, 8'h00);
        @(posedge mclk);
        rst_n <= 1'b1;
        apb(1'b1, OFS_DIRECTION, 32'hFF);
        apb(1'b0, OFS_OUTPUT_LATCH, 32'h0);
        chk(r, 32'h0);
        apb(1'b0, OFS_PULLUP_CONTROL, 32'h0);
        chk(r, 32'h0);
        summarize();
    end
endmodule // port1_gpio_with_pwm_mux_tb_top
